// ==== pkg/clock_synth_pkg.sv ====
// package: widths, codes and carrier types of the three-loop clock synthesizer control
// assumes one 10 MHz reference clock (clock_i) and a synchronous power-up reset
`default_nettype none
package clock_synth_pkg;
  localparam int PRE_WIDTH      = 8;
  localparam int FB_WIDTH       = 11;
  localparam int POST_WIDTH     = 7;
  localparam int ACC_WIDTH      = 12;
  localparam int NUM_LOOPS      = 3;
  localparam int NUM_XOUT       = 4;
  localparam int NUM_OUTS       = 5;
  localparam int TABLE_ROWS     = 8;
  localparam int SEL_WIDTH      = 3;
  localparam int NUM_PINS       = 4;
  // pin vector positions
  localparam int PIN_DATA       = 0;
  localparam int PIN_SCLK       = 1;
  localparam int PIN_SEL2       = 2;
  localparam int PIN_SHUT       = 3;
  localparam logic [3:0] PIN_FILT_RESET = 4'h0;
  // cycles after reset release before the strap pins are trusted
  localparam logic [2:0] STARTUP_CYCLES = 3'h4;
  // cross-point source codes
  localparam logic [1:0] SRC_REF   = 2'h0;
  localparam logic [1:0] SRC_LOOP1 = 2'h1;
  localparam logic [1:0] SRC_LOOP2 = 2'h2;
  localparam logic [1:0] SRC_LOOP3 = 2'h3;
  // fifth output post-divider codes; code value is also the last edge index
  localparam logic [1:0] E_OFF  = 2'h0;
  localparam logic [1:0] E_DIV2 = 2'h1;
  localparam logic [1:0] E_DIV3 = 2'h2;
  localparam logic [1:0] E_DIV4 = 2'h3;

  typedef struct packed {
    logic [PRE_WIDTH-1:0] pre;
    logic [FB_WIDTH-1:0]  fb;
  } loop_cfg_t;

  typedef struct packed {
    loop_cfg_t cfg;
    logic      div_reg_sel;
  } loop_one_row_t;

  typedef struct packed {
    logic [POST_WIDTH-1:0] a;
    logic [POST_WIDTH-1:0] b;
  } ab_div_t;

  typedef enum logic [2:0] {
    E_ST_OFF  = 3'b001,
    E_ST_RUN  = 3'b010,
    E_ST_HOLD = 3'b100
  } e_state_t;
endpackage
`default_nettype wire

// ==== core/edge_divider.sv ====
// module: programmable divider counting source edges, 50 percent duty for any nonzero ratio; ratio 0 holds the output low
// assumes edge_i marks one source clock edge per pulse, on clock_i
`default_nettype none
module edge_divider #(
  parameter int WIDTH = 7
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             run_i,
  input  wire logic             edge_i,
  input  wire logic [WIDTH-1:0] ratio_i,
  output var  logic             clock_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] active;

  // new ratio is taken at a toggle, or at the first edge while active is zero, so no runt pulse on a change
  always_ff @(posedge clock_i) begin
    if (reset_i || !run_i) begin
      count   <= '0;
      active  <= '0;
      clock_o <= 1'b0;
    end else if (edge_i) begin
      if (active == '0) begin
        active <= ratio_i; // RL12
        count  <= '0;
      end else if (count == active - 1'b1) begin
        count   <= '0;
        active  <= ratio_i; // RL12
        clock_o <= clock_o ? 1'b0 : (ratio_i != '0);
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  property p_toggle_on_edge;
    @(posedge clock_i) disable iff (reset_i)
    (run_i && $past(run_i) && $changed(clock_o)) |-> $past(edge_i);
  endproperty
  a_toggle_on_edge: assert property (p_toggle_on_edge) else $error("divider output moved without a source edge"); // RL12
endmodule
`default_nettype wire

// ==== core/clock_synth_ctrl.sv ====
// module: digital control of a three-loop clock synthesizer with cross-point and power pins
// assumes loop and reference clocks are modelled as edge pulses on clock_i; pins are asynchronous
`default_nettype none
// How it works
// RL1: each loop makes edges at the reference rate times feedback value over 8-bit pre-divider value.
// RL2: the edges of all three loops are offered to the cross-point switch.
// RL3: loop one also feeds a post-divider of 2, 3 or 4 that drives the fifth output.
// RL4: the dividers behind the cross-point are 7 bits wide.
// RL5: loop one takes its setting from the serial value or from the select-indexed table.
// RL6: loops two and three take only their serial values and ignore the select inputs.
// RL7: the data and clock pins are latched once at start-up as select bits 0 and 1 and held.
// RL8: the third select pin is select bit 2, or the suspend control when so configured.
// RL9: by default a low shutdown pin turns all outputs off and stops the whole chip.
// RL10: with output-enable-only set, a low shutdown pin turns outputs off but the chip runs.
// RL11: any of reference and three loops can be routed to any of the four output dividers.
// RL12: the three select bits index an eight-row table and divider changes are glitch-free.
// RL13: outputs a and b share one choice between their register 0 and register 1 dividers.
// RL14: the fifth output is held low while its ratio changes and resumes at the next loop-one edge.
module clock_synth_ctrl (
  input  wire logic                                                    clock_i,
  input  wire logic                                                    reset_i,
  input  wire logic                                                    serial_port_data_pin_i,
  input  wire logic                                                    serial_port_clock_pin_i,
  input  wire logic                                                    select_or_suspend_pin_i,
  input  wire logic                                                    shutdown_oe_n_pin_i,
  input  wire logic                                                    oe_only_i,
  input  wire logic                                                    select_is_suspend_i,
  input  wire logic [clock_synth_pkg::NUM_OUTS-1:0]                    suspend_mask_i,
  input  wire logic                                                    loop_one_use_table_i,
  input  wire clock_synth_pkg::loop_cfg_t                              loop_one_serial_cfg_i,
  input  wire logic                                                    loop_one_serial_sel_i,
  input  wire clock_synth_pkg::loop_one_row_t [clock_synth_pkg::TABLE_ROWS-1:0] loop_one_table_i,
  input  wire clock_synth_pkg::loop_cfg_t                              loop_two_cfg_i,
  input  wire clock_synth_pkg::loop_cfg_t                              loop_three_cfg_i,
  input  wire clock_synth_pkg::ab_div_t                                ab_div_reg0_i,
  input  wire clock_synth_pkg::ab_div_t                                ab_div_reg1_i,
  input  wire logic [clock_synth_pkg::POST_WIDTH-1:0]                  div_c_i,
  input  wire logic [clock_synth_pkg::POST_WIDTH-1:0]                  div_d_i,
  input  wire logic [clock_synth_pkg::NUM_XOUT-1:0][1:0]               xpoint_sel_i,
  input  wire logic [1:0]                                              e_ratio_i,
  output var  logic                                                    output_clock_a_o,
  output var  logic                                                    output_clock_b_o,
  output var  logic                                                    output_clock_c_o,
  output var  logic                                                    output_clock_d_o,
  output var  logic                                                    loop_one_divided_output_o,
  output var  logic [clock_synth_pkg::NUM_OUTS-1:0]                    clocks_oe_n_o,
  output var  logic                                                    chip_running_o,
  output var  logic [clock_synth_pkg::NUM_LOOPS-1:0]                   loop_edge_o,
  output var  logic [clock_synth_pkg::SEL_WIDTH-1:0]                   freq_select_o,
  output var  clock_synth_pkg::loop_cfg_t                              loop_one_cfg_o
);
  logic [3:0]  pin_raw;
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic [3:0]  pin_filt;
  logic [2:0]  startup_count;
  logic        straps_latched;
  logic [1:0]  strap_bits;
  logic        ab_sel;
  logic        suspend_low;
  logic [clock_synth_pkg::NUM_OUTS-1:0] next_oe_n;
  clock_synth_pkg::loop_cfg_t [clock_synth_pkg::NUM_LOOPS-1:0] loop_cfg;
  logic [clock_synth_pkg::NUM_LOOPS:0]  src_edge;
  logic [clock_synth_pkg::NUM_XOUT-1:0] xclk;
  logic [clock_synth_pkg::NUM_XOUT-1:0][clock_synth_pkg::POST_WIDTH-1:0] xratio;
  clock_synth_pkg::e_state_t e_state;
  logic [1:0]  e_active;
  logic [1:0]  e_count;

  function automatic logic [clock_synth_pkg::POST_WIDTH-1:0] pick_reg(
    input logic                                  sel,
    input logic [clock_synth_pkg::POST_WIDTH-1:0] r0,
    input logic [clock_synth_pkg::POST_WIDTH-1:0] r1
  );
    return sel ? r1 : r0;
  endfunction

  // three-stage pin sampling; a change counts once stages two and three agree
  assign pin_raw = {shutdown_oe_n_pin_i, select_or_suspend_pin_i, serial_port_clock_pin_i, serial_port_data_pin_i};
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1    <= clock_synth_pkg::PIN_FILT_RESET;
      sync2    <= clock_synth_pkg::PIN_FILT_RESET;
      sync3    <= clock_synth_pkg::PIN_FILT_RESET;
      pin_filt <= clock_synth_pkg::PIN_FILT_RESET;
    end else begin
      sync1    <= pin_raw;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_filt <= (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & pin_filt);
    end
  end

  // straps caught once the sampler has filled; afterwards the pins belong to the serial port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      startup_count  <= 3'h0;
      straps_latched <= 1'b0;
      strap_bits     <= 2'h0;
    end else if (!straps_latched) begin
      if (startup_count == clock_synth_pkg::STARTUP_CYCLES) begin
        straps_latched <= 1'b1;
        strap_bits     <= {pin_filt[clock_synth_pkg::PIN_SCLK], pin_filt[clock_synth_pkg::PIN_DATA]}; // RL7
      end else begin
        startup_count <= startup_count + 3'h1;
      end
    end
  end

  // third pin is either select bit 2 or the suspend line, never both
  assign freq_select_o = {(!select_is_suspend_i && pin_filt[clock_synth_pkg::PIN_SEL2]), strap_bits}; // RL8 RL12
  assign suspend_low   = select_is_suspend_i && !pin_filt[clock_synth_pkg::PIN_SEL2]; // RL8

  // loop-one setting and shared a/b register choice, registered so a change lands on one edge
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loop_one_cfg_o <= '0;
      ab_sel         <= 1'b0;
    end else if (loop_one_use_table_i) begin
      loop_one_cfg_o <= loop_one_table_i[freq_select_o].cfg; // RL5 RL12
      ab_sel         <= loop_one_table_i[freq_select_o].div_reg_sel; // RL13
    end else begin
      loop_one_cfg_o <= loop_one_serial_cfg_i; // RL5
      ab_sel         <= loop_one_serial_sel_i;
    end
  end

  // power state: shutdown stops everything unless only output enable is wanted
  assign next_oe_n = ~({clock_synth_pkg::NUM_OUTS{straps_latched && pin_filt[clock_synth_pkg::PIN_SHUT]}}
                       & ~({clock_synth_pkg::NUM_OUTS{suspend_low}} & suspend_mask_i)); // RL9 RL10
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      clocks_oe_n_o  <= '1;
      chip_running_o <= 1'b0;
    end else begin
      clocks_oe_n_o  <= next_oe_n;
      chip_running_o <= straps_latched && (pin_filt[clock_synth_pkg::PIN_SHUT] || oe_only_i); // RL9 RL10
    end
  end

  // loops two and three see only their own serial values
  assign loop_cfg[0] = loop_one_cfg_o;
  assign loop_cfg[1] = loop_two_cfg_i; // RL6
  assign loop_cfg[2] = loop_three_cfg_i; // RL6

  // rate model: one edge per carry, so a loop saturates at one edge per clock when fb exceeds pre
  for (genvar g = 0; g < clock_synth_pkg::NUM_LOOPS; g++) begin : g_loop
    logic [clock_synth_pkg::ACC_WIDTH-1:0] acc;
    logic [clock_synth_pkg::ACC_WIDTH-1:0] sum;
    logic [clock_synth_pkg::ACC_WIDTH-1:0] diff;
    logic [clock_synth_pkg::ACC_WIDTH-1:0] pre_wide;
    logic                                  edge_q;
    assign pre_wide = {4'h0, loop_cfg[g].pre};
    assign sum      = acc + {1'b0, loop_cfg[g].fb};
    assign diff     = sum - pre_wide;
    always_ff @(posedge clock_i) begin
      if (reset_i || !chip_running_o || loop_cfg[g].pre == '0) begin
        acc    <= '0;
        edge_q <= 1'b0;
      end else if (sum >= pre_wide) begin
        edge_q <= 1'b1; // RL1
        acc    <= (diff >= pre_wide) ? '0 : diff;
      end else begin
        edge_q <= 1'b0;
        acc    <= sum; // RL1
      end
    end
    assign loop_edge_o[g] = edge_q;
  end

  // cross-point: source 0 is the reference, one edge per clock
  assign src_edge = {loop_edge_o, chip_running_o}; // RL2
  assign xratio[0] = pick_reg(ab_sel, ab_div_reg0_i.a, ab_div_reg1_i.a); // RL13
  assign xratio[1] = pick_reg(ab_sel, ab_div_reg0_i.b, ab_div_reg1_i.b); // RL13
  assign xratio[2] = div_c_i;
  assign xratio[3] = div_d_i;
  for (genvar k = 0; k < clock_synth_pkg::NUM_XOUT; k++) begin : g_xout
    edge_divider #(
      .WIDTH (clock_synth_pkg::POST_WIDTH) // RL4
    ) u_div (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .run_i   (chip_running_o),
      .edge_i  (src_edge[xpoint_sel_i[k]]), // RL11
      .ratio_i (xratio[k]),
      .clock_o (xclk[k])
    );
  end
  assign output_clock_a_o = xclk[0];
  assign output_clock_b_o = xclk[1];
  assign output_clock_c_o = xclk[2];
  assign output_clock_d_o = xclk[3];

  // fifth output: a ratio change waits for a low phase, then holds low until a loop-one edge
  always_ff @(posedge clock_i) begin
    if (reset_i || !chip_running_o) begin
      e_state                   <= clock_synth_pkg::E_ST_OFF;
      e_active                  <= clock_synth_pkg::E_OFF;
      e_count                   <= 2'h0;
      loop_one_divided_output_o <= 1'b0;
    end else begin
      unique case (e_state)
        clock_synth_pkg::E_ST_OFF: begin
          if (e_ratio_i != clock_synth_pkg::E_OFF) begin
            e_state <= clock_synth_pkg::E_ST_HOLD;
          end
        end
        clock_synth_pkg::E_ST_HOLD: begin
          loop_one_divided_output_o <= 1'b0; // RL14
          if (loop_edge_o[0]) begin
            e_active <= e_ratio_i; // RL14
            e_count  <= 2'h0;
            e_state  <= (e_ratio_i == clock_synth_pkg::E_OFF) ? clock_synth_pkg::E_ST_OFF : clock_synth_pkg::E_ST_RUN;
          end
        end
        clock_synth_pkg::E_ST_RUN: begin
          if (loop_edge_o[0] && e_count == e_active) begin
            e_count <= 2'h0;
            if (e_ratio_i != e_active) begin
              loop_one_divided_output_o <= 1'b0; // RL14
              e_state                   <= clock_synth_pkg::E_ST_HOLD;
            end else begin
              loop_one_divided_output_o <= ~loop_one_divided_output_o; // RL3
            end
          end else begin
            if (e_ratio_i != e_active && !loop_one_divided_output_o) begin
              e_state <= clock_synth_pkg::E_ST_HOLD; // RL14
            end
            if (loop_edge_o[0]) begin
              e_count <= e_count + 2'h1; // RL3
            end
          end
        end
        default: begin
          e_state <= clock_synth_pkg::E_ST_OFF;
        end
      endcase
    end
  end

  property p_shutdown_all;
    @(posedge clock_i) disable iff (reset_i)
    (!pin_filt[clock_synth_pkg::PIN_SHUT] && !oe_only_i) |=> (&clocks_oe_n_o && !chip_running_o);
  endproperty
  a_shutdown_all: assert property (p_shutdown_all) else $error("shutdown left outputs or chip on"); // RL9

  property p_oe_only;
    @(posedge clock_i) disable iff (reset_i)
    (!pin_filt[clock_synth_pkg::PIN_SHUT] && oe_only_i && straps_latched) |=> (&clocks_oe_n_o && chip_running_o);
  endproperty
  a_oe_only: assert property (p_oe_only) else $error("output-enable-only mode stopped the chip"); // RL10

  property p_straps_hold;
    @(posedge clock_i) disable iff (reset_i)
    straps_latched |=> ($stable(strap_bits) && straps_latched);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("latched select bits moved"); // RL7

  property p_loop_off;
    @(posedge clock_i) disable iff (reset_i)
    loop_edge_o[1] |-> ($past(loop_two_cfg_i.pre) != '0 && $past(chip_running_o));
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop two made an edge while off"); // RL1

  // output d routed from loop two may only move after a loop-two edge; a wrong mux select trips it
  property p_route_d;
    @(posedge clock_i) disable iff (reset_i)
    (chip_running_o && $past(chip_running_o) && $past(xpoint_sel_i[3]) == clock_synth_pkg::SRC_LOOP2
      && $changed(output_clock_d_o)) |-> $past(loop_edge_o[1]);
  endproperty
  a_route_d: assert property (p_route_d) else $error("output d moved without a routed loop-two edge"); // RL11

  property p_e_hold_low;
    @(posedge clock_i) disable iff (reset_i)
    (e_state == clock_synth_pkg::E_ST_HOLD) |=> (!loop_one_divided_output_o || $past(e_state) != e_state);
  endproperty
  a_e_hold_low: assert property (p_e_hold_low) else $error("fifth output high while held"); // RL14

  property p_e_resume;
    @(posedge clock_i) disable iff (reset_i)
    (e_state == clock_synth_pkg::E_ST_HOLD && loop_edge_o[0] && e_ratio_i != clock_synth_pkg::E_OFF && chip_running_o)
      |=> (e_state == clock_synth_pkg::E_ST_RUN && e_active == $past(e_ratio_i));
  endproperty
  a_e_resume: assert property (p_e_resume) else $error("fifth output did not resume on loop-one edge"); // RL14

  property p_e_divide;
    @(posedge clock_i) disable iff (reset_i)
    (e_state == clock_synth_pkg::E_ST_RUN && e_ratio_i == e_active && loop_edge_o[0] && e_count == e_active
      && chip_running_o) |=> (loop_one_divided_output_o != $past(loop_one_divided_output_o));
  endproperty
  a_e_divide: assert property (p_e_divide) else $error("fifth output missed its toggle"); // RL3
endmodule
`default_nettype wire

// ==== test/host_pin_model.sv ====
// partner: host side of the strap, select and shutdown pins
// assumes the bench drives its controls at the falling edge of clock_i
`default_nettype none
module host_pin_model (
  input  wire logic       clock_i,
  input  wire logic [2:0] strap_i,
  input  wire logic       traffic_i,
  input  wire logic       shut_n_i,
  output var  logic       data_pin_o,
  output var  logic       sclk_pin_o,
  output var  logic       sel_pin_o,
  output var  logic       shut_n_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins are first driven at the first falling edge, well inside reset
  logic [1:0] phase = 2'h0;

  // straps stand still until bus traffic starts; traffic then moves the data pin every cycle and the clock pin every second cycle
  always @(negedge clock_i) begin
    phase <= phase + 2'h1;
    data_pin_o <= traffic_i ? (phase[0] ^ ~strap_i[0]) : strap_i[0];
    sclk_pin_o <= traffic_i ? (phase[1] ^ ~strap_i[1]) : strap_i[1];
  end

  // select and shutdown lines are plain levels from the host
  assign sel_pin_o = strap_i[2];
  assign shut_n_pin_o = shut_n_i;
endmodule
`default_nettype wire

// ==== test/tb_clock_synth_ctrl.sv ====
// bench: self-checking test of the three-loop synthesizer control
// assumes host_pin_model on the pins; notes queued, judged by a watcher process
`default_nettype none
module tb_clock_synth_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    string       name;
    logic [31:0] lo;
    logic [31:0] hi;
  } note_t;
  logic                                 clock_i;
  logic                                 reset_i;
  logic                                 oe_only;
  logic                                 sel_susp;
  logic                                 use_table;
  logic                                 serial_sel;
  logic                                 traffic;
  logic                                 shut_n;
  logic [2:0]                           strap;
  logic [4:0]                           susp_mask;
  logic [1:0]                           e_ratio;
  logic [6:0]                           div_c;
  logic [6:0]                           div_d;
  logic [3:0][1:0]                      xsel;
  clock_synth_pkg::loop_cfg_t           l1_ser;
  clock_synth_pkg::loop_cfg_t           l2_cfg;
  clock_synth_pkg::loop_cfg_t           l3_cfg;
  clock_synth_pkg::loop_cfg_t           l1_cfg;
  clock_synth_pkg::loop_one_row_t [7:0] table_v;
  clock_synth_pkg::ab_div_t             reg0;
  clock_synth_pkg::ab_div_t             reg1;
  wire logic                            data_pin;
  wire logic                            sclk_pin;
  wire logic                            sel_pin;
  wire logic                            shut_pin;
  logic                                 clk_a;
  logic                                 clk_b;
  logic                                 clk_c;
  logic                                 clk_d;
  logic                                 clk_e;
  logic                                 running;
  logic [4:0]                           oe_n;
  logic [2:0]                           loop_edge;
  logic [2:0]                           fsel;
  wire logic [7:0]                      obs = {loop_edge, clk_e, clk_d, clk_c, clk_b, clk_a};
  int                                   mismatches;
  int                                   compares;
  int                                   fbv[4];
  int                                   prv[4];
  note_t                                notes[$];
  logic [31:0]                          got;
  event                                 result_ev;

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  clock_synth_ctrl clock_synth_ctrl_i (
    .clock_i(clock_i), .reset_i(reset_i), .serial_port_data_pin_i(data_pin), .serial_port_clock_pin_i(sclk_pin),
    .select_or_suspend_pin_i(sel_pin), .shutdown_oe_n_pin_i(shut_pin), .oe_only_i(oe_only),
    .select_is_suspend_i(sel_susp), .suspend_mask_i(susp_mask), .loop_one_use_table_i(use_table),
    .loop_one_serial_cfg_i(l1_ser), .loop_one_serial_sel_i(serial_sel), .loop_one_table_i(table_v),
    .loop_two_cfg_i(l2_cfg), .loop_three_cfg_i(l3_cfg), .ab_div_reg0_i(reg0), .ab_div_reg1_i(reg1),
    .div_c_i(div_c), .div_d_i(div_d), .xpoint_sel_i(xsel), .e_ratio_i(e_ratio),
    .output_clock_a_o(clk_a), .output_clock_b_o(clk_b), .output_clock_c_o(clk_c), .output_clock_d_o(clk_d),
    .loop_one_divided_output_o(clk_e), .clocks_oe_n_o(oe_n), .chip_running_o(running),
    .loop_edge_o(loop_edge), .freq_select_o(fsel), .loop_one_cfg_o(l1_cfg));

  host_pin_model host_pin_model_i (
    .clock_i(clock_i), .strap_i(strap), .traffic_i(traffic), .shut_n_i(shut_n),
    .data_pin_o(data_pin), .sclk_pin_o(sclk_pin), .sel_pin_o(sel_pin), .shut_n_pin_o(shut_pin));

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // note the expected window first, then hand the seen value to the watcher
  task automatic check(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] val);
    notes.push_back('{name, lo, hi});
    got = val;
    ->result_ev;
    #1;
  endtask

  // oldest note against each result; an unknown never lands inside the window
  always @(result_ev) begin
    note_t n;
    n = notes.pop_front();
    compares++;
    if (((got >= n.lo) && (got <= n.hi)) !== 1'b1) begin
      mismatches++;
      $display("ERROR %s expected %0d..%0d seen %0d", n.name, n.lo, n.hi, got);
    end
  end

  // toggles (or pulses for loop edges) over w cycles; +-2 covers phase at the window ends
  task automatic meas(input string name, input int idx, input int w, input int e);
    logic        prev;
    logic [31:0] n;
    n = 32'h0000_0000;
    @(negedge clock_i);
    prev = obs[idx];
    repeat (w) begin
      @(negedge clock_i);
      if (idx >= 5 ? obs[idx] : (obs[idx] !== prev)) n++;
      prev = obs[idx];
    end
    check(name, (e > 2) ? e - 2 : 0, e + 2, n);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  initial begin
    void'($urandom(32'h5032));
    {reset_i, traffic, shut_n, oe_only, sel_susp, use_table, serial_sel} = 7'h50;
    strap = 3'($urandom());
    susp_mask = 5'h00;
    e_ratio = clock_synth_pkg::E_DIV2;
    div_c = 7'h7f;
    div_d = 7'h01;
    xsel = {4{clock_synth_pkg::SRC_REF}};
    l1_ser = '{pre: 8'h03, fb: 11'h002};
    l2_cfg.pre = 8'($urandom_range(16, 2));
    l2_cfg.fb = 11'($urandom_range(l2_cfg.pre - 1, 1));
    l3_cfg.pre = 8'($urandom_range(40, 17));
    l3_cfg.fb = 11'($urandom_range(l3_cfg.pre - 1, 1));
    reg0 = '{a: 7'h02, b: 7'h04};
    reg1 = '{a: 7'h04, b: 7'h02};
    for (int i = 0; i < 8; i++) table_v[i] = '{cfg: '{pre: 8'(i + 2), fb: 11'h001}, div_reg_sel: 1'(i)};
    fbv = '{1, 2, int'(l2_cfg.fb), int'(l3_cfg.fb)};
    prv = '{1, 3, int'(l2_cfg.pre), int'(l3_cfg.pre)};
    wait_cycles(3);
    reset_i = 1'b0;
    for (int i = 0; i < 20 && running !== 1'b1; i++) @(negedge clock_i);
    check("chip_running", 1, 1, 32'(running));
    if (running !== 1'b1) results();
    // straps must hold while the serial pins carry traffic
    traffic = 1'b1;
    wait_cycles(10);
    check("freq_select", 32'(strap), 32'(strap), 32'(fsel));
    // a and b follow one shared register choice
    for (int j = 0; j < 2; j++) begin
      serial_sel = 1'(j);
      wait_cycles(10);
      meas("clock_a", 0, 120, j ? 30 : 60);
      meas("clock_b", 1, 120, j ? 60 : 30);
    end
    meas("clock_c_div127", 2, 1000, 1000 / 127);
    // every source through the cross-point into output d
    for (int s = 0; s < 4; s++) begin
      xsel[3] = 2'(s);
      wait_cycles(10);
      meas("clock_d", 3, 240, 240 * fbv[s] / prv[s]);
    end
    // fifth output for ratio codes 1 to 3 (E_OFF not driven), loop one at 2/3 edge per cycle
    for (int c = 1; c < 4; c++) begin
      e_ratio = 2'(c);
      wait_cycles(20);
      meas("clock_e", 4, 240, 160 / (c + 1));
    end
    use_table = 1'b1;
    wait_cycles(4);
    check("loop_one_cfg", 32'(table_v[strap].cfg), 32'(table_v[strap].cfg), 32'(l1_cfg));
    strap[2] = ~strap[2];
    wait_cycles(10);
    check("loop_one_cfg", 32'(table_v[strap].cfg), 32'(table_v[strap].cfg), 32'(l1_cfg));
    meas("loop_one_edges", 5, 600, 600 / (int'(strap) + 2));
    meas("loop_two_edges", 6, 600, 600 * fbv[2] / prv[2]);
    meas("loop_three_edges", 7, 600, 600 * fbv[3] / prv[3]);
    use_table = 1'b0;
    wait_cycles(3);
    check("loop_one_cfg", 32'(l1_ser), 32'(l1_ser), 32'(l1_cfg));
    // full shutdown, then output-enable-only, then suspend with a random mask
    shut_n = 1'b0;
    wait_cycles(8);
    check("oe_n", 32'h0000_001f, 32'h0000_001f, 32'(oe_n));
    check("chip_running", 0, 0, 32'(running));
    meas("clock_c_stopped", 2, 100, 0);
    {shut_n, oe_only} = 2'h3;
    wait_cycles(8);
    shut_n = 1'b0;
    wait_cycles(8);
    check("oe_n", 32'h0000_001f, 32'h0000_001f, 32'(oe_n));
    check("chip_running", 1, 1, 32'(running));
    shut_n = 1'b1;
    wait_cycles(8);
    check("oe_n", 0, 0, 32'(oe_n));
    {sel_susp, strap[2]} = 2'h2;
    susp_mask = 5'($urandom());
    wait_cycles(8);
    check("oe_n", 32'(susp_mask), 32'(susp_mask), 32'(oe_n));
    check("select_bit2", 0, 0, 32'(fsel[2]));
    results();
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
